// [adcc_pkg.sv]
// Package for the conversion control block: register map, fields, timing
package adcc_pkg;

  // ==========================================================================
  // Register indices (byte offsets are index values on the plain port)
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic [1:0] ADDR_RESULT = 2'h1;
  localparam logic [1:0] ADDR_START = 2'h2;
  localparam logic [1:0] ADDR_IRQ = 2'h3;

  // ==========================================================================
  // Field positions and reset values
  localparam int MODE_SPEED_BIT = 7;
  localparam int MODE_TRIG_BIT = 6;
  localparam logic [7:0] MODE_RESET = 8'h30;
  localparam logic [7:0] MODE_FIXED_ONES = 8'h30;
  localparam logic [7:0] START_FIXED_ONES = 8'h7F;
  localparam int START_FLAG_BIT = 7;
  localparam int IRQ_REQ_BIT = 0;
  localparam int IRQ_EN_BIT = 1;

  // ==========================================================================
  // Conversion timing in system clock periods
  localparam logic [6:0] SLOW_CYCLES = 7'h3E;
  localparam logic [6:0] FAST_CYCLES = 7'h1F;
  localparam int RESULT_BITS = 8;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_BUSY = 2'b10
  } adcc_state_type;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_type;

  typedef struct packed {
    logic active;
    logic [2:0] input_idx;
  } adcc_chan_type;

endpackage

// [adcc_core.sv]
// Conversion control for an eight-input, 8-bit successive-approximation converter
// ============================================================================
// Functional notes
// RULE_01: Result held in 8-bit register until next start
// RULE_02: Result readable anytime; undefined while converting
// RULE_03: Reset leaves result register untouched
// RULE_04: Mode register resets to 30 hex
// RULE_05: Bit 7 selects 62 or 31 clock conversion
// RULE_06: Software keeps conversion time at least 12.4us
// RULE_07: Bit 6 gates external trigger edges
// RULE_08: Trigger polarity from external edge-select bit
// RULE_09: Mode bits 5,4 read one, ignore writes
// RULE_10: Start bits 6..0 read one, ignore writes
// RULE_11: Channel decode: none, 0-3, 4-7, reserved
// RULE_12: Software stops conversion before changing mode
// RULE_13: Start by flag write or enabled edge
// RULE_14: Flag reads busy; writing zero stops conversion
// RULE_15: Completion loads result and clears flag together
// RULE_16: Done request set on flag falling at end
// RULE_17: Interrupt raised only when enable is set
// RULE_18: Successive approximation yields one 8-bit code
// RULE_19: Idle after completion until next start
// RULE_20: Software reads result only when flag clear
// RULE_21: Cycle counter times 62 or 31 cycles
// RULE_22: Stop writes neither result nor done request
// RULE_23: Trigger pin synchronised, edge from successive samples
`timescale 1ns/1ns
`default_nettype none

module adcc_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Trigger pin and its polarity (1 = rising, 0 = falling)
  input wire logic ext_trigger_pin,
  input wire logic trigger_edge_select,
  // Analog front end
  input wire logic compare_above,
  output logic [7:0] dac_code,
  output logic [2:0] input_select,
  output logic input_active,
  output logic sample_hold,
  // Interrupt
  output logic conversion_done_irq
);

  // ==========================================================================
  // Helpers
  function automatic adcc_pkg::adcc_chan_type decode_channel(input logic [3:0] ch);
    adcc_pkg::adcc_chan_type c;
    c.active = (ch[3:2] == 2'b01) || (ch[3:2] == 2'b10); // RULE_11
    c.input_idx = {ch[3], ch[1:0]}; // RULE_11
    return c;
  endfunction

  function automatic logic [6:0] period_of(input logic speed);
    return speed ? adcc_pkg::FAST_CYCLES : adcc_pkg::SLOW_CYCLES; // RULE_05
  endfunction

  adcc_pkg::adcc_bus_type bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================================
  // Registers
  logic speed_select_reg;
  logic ext_trigger_enable_reg;
  logic [3:0] channel_sel_reg;
  logic convert_flag_reg;
  logic [7:0] conversion_result_reg;
  logic conversion_done_request_reg;
  logic conversion_done_irq_enable_reg;
  adcc_pkg::adcc_state_type state_reg;
  logic [6:0] cycle_cnt_reg;
  logic [7:0] sar_reg;
  logic [7:0] trial_bit_reg;
  logic trig_sync1_reg;
  logic trig_sync2_reg;
  logic trig_prev_reg;

  logic wr_mode;
  logic wr_start;
  logic wr_irq;
  logic trig_edge;
  logic finish;
  logic start_now;
  logic stop_now;
  logic [6:0] period;
  logic [6:0] step_at;
  logic step_now;
  adcc_pkg::adcc_chan_type chan;

  assign wr_mode = bus.wr && (bus.addr == adcc_pkg::ADDR_MODE);
  assign wr_start = bus.wr && (bus.addr == adcc_pkg::ADDR_START);
  assign wr_irq = bus.wr && (bus.addr == adcc_pkg::ADDR_IRQ);
  assign period = period_of(speed_select_reg);
  // Approximation steps sit in the tail of the period so sampling gets the front;
  // the last step lands one cycle before finish so the result holds every bit
  assign step_at = period - 7'h09;
  assign step_now = (state_reg == adcc_pkg::ADCC_BUSY) && (cycle_cnt_reg >= step_at) &&
    (trial_bit_reg != 8'h00);
  assign chan = decode_channel(channel_sel_reg);

  // ==========================================================================
  // Trigger synchroniser and edge detect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_sync1_reg <= 1'b0;
      trig_sync2_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_sync1_reg <= ext_trigger_pin; // RULE_23
      trig_sync2_reg <= trig_sync1_reg; // RULE_23
      trig_prev_reg <= trig_sync2_reg; // RULE_23
    end
  end

  assign trig_edge = ext_trigger_enable_reg && // RULE_07
    (trigger_edge_select ? (trig_sync2_reg && !trig_prev_reg) // RULE_08
                         : (!trig_sync2_reg && trig_prev_reg)); // RULE_23

  assign stop_now = wr_start && !bus.wdata[adcc_pkg::START_FLAG_BIT]; // RULE_14
  assign start_now = !stop_now &&
    ((wr_start && bus.wdata[adcc_pkg::START_FLAG_BIT]) || trig_edge); // RULE_13
  assign finish = (state_reg == adcc_pkg::ADCC_BUSY) && !stop_now && !start_now &&
    (cycle_cnt_reg == period - 7'h01); // RULE_21

  // ==========================================================================
  // Mode register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      speed_select_reg <= adcc_pkg::MODE_RESET[adcc_pkg::MODE_SPEED_BIT]; // RULE_04
      ext_trigger_enable_reg <= adcc_pkg::MODE_RESET[adcc_pkg::MODE_TRIG_BIT]; // RULE_04
      channel_sel_reg <= adcc_pkg::MODE_RESET[3:0]; // RULE_04
    end else if (wr_mode) begin
      // Bits 5 and 4 have no storage, so writes there are dropped
      speed_select_reg <= bus.wdata[adcc_pkg::MODE_SPEED_BIT]; // RULE_05
      ext_trigger_enable_reg <= bus.wdata[adcc_pkg::MODE_TRIG_BIT]; // RULE_07
      channel_sel_reg <= bus.wdata[3:0]; // RULE_09
    end
  end

  // ==========================================================================
  // Start flag and sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= adcc_pkg::ADCC_IDLE;
      convert_flag_reg <= 1'b0;
      cycle_cnt_reg <= 7'h00;
    end else begin
      if (start_now) begin
        // A fresh start restarts the timing even mid-conversion
        state_reg <= adcc_pkg::ADCC_BUSY; // RULE_13
        convert_flag_reg <= 1'b1; // RULE_13
        cycle_cnt_reg <= 7'h00;
      end else if (stop_now || finish) begin
        state_reg <= adcc_pkg::ADCC_IDLE; // RULE_19
        convert_flag_reg <= 1'b0; // RULE_15
        cycle_cnt_reg <= 7'h00;
      end else begin
        case (state_reg)
          adcc_pkg::ADCC_IDLE: cycle_cnt_reg <= 7'h00; // RULE_19
          adcc_pkg::ADCC_BUSY: cycle_cnt_reg <= cycle_cnt_reg + 7'h01; // RULE_21
          default: state_reg <= adcc_pkg::ADCC_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Successive approximation and result
  // No reset on these: the result must survive reset unchanged
  always_ff @(posedge ref_clk) begin
    if (start_now) begin
      sar_reg <= 8'h00;
      trial_bit_reg <= 8'h80;
    end else if (step_now) begin
      if (compare_above) begin
        sar_reg <= sar_reg | trial_bit_reg; // RULE_18
      end
      trial_bit_reg <= trial_bit_reg >> 1; // RULE_18
    end
  end

  // Trial code kept equal to sar|trial so the comparator never sees a stale code
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_code <= 8'h00;
    end else if (start_now) begin
      dac_code <= 8'h80;
    end else if (step_now) begin
      dac_code <= (compare_above ? dac_code : (dac_code & ~trial_bit_reg)) |
        (trial_bit_reg >> 1); // RULE_18
    end
  end

  always_ff @(posedge ref_clk) begin
    if (finish) begin
      conversion_result_reg <= sar_reg; // RULE_01 RULE_15 RULE_03 RULE_22
    end
  end

  // ==========================================================================
  // Done request and interrupt
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conversion_done_request_reg <= 1'b0;
      conversion_done_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_irq) begin
        conversion_done_irq_enable_reg <= bus.wdata[adcc_pkg::IRQ_EN_BIT];
      end
      // Set wins over a software clear in the same cycle
      if (finish) begin
        conversion_done_request_reg <= 1'b1; // RULE_16 RULE_22
      end else if (wr_irq && !bus.wdata[adcc_pkg::IRQ_REQ_BIT]) begin
        conversion_done_request_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= conversion_done_request_reg &&
                             conversion_done_irq_enable_reg; // RULE_17
    end
  end

  // ==========================================================================
  // Analog front-end drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_select <= 3'h0;
      input_active <= 1'b0;
      sample_hold <= 1'b0;
    end else begin
      input_select <= chan.input_idx; // RULE_11
      input_active <= chan.active; // RULE_11
      sample_hold <= (state_reg == adcc_pkg::ADCC_BUSY) && (cycle_cnt_reg < step_at);
    end
  end

  // ==========================================================================
  // Read data, valid in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        adcc_pkg::ADDR_MODE: reg_rdata <= {speed_select_reg, ext_trigger_enable_reg,
          2'b00, channel_sel_reg} | adcc_pkg::MODE_FIXED_ONES; // RULE_09
        adcc_pkg::ADDR_RESULT: reg_rdata <= conversion_result_reg; // RULE_02
        adcc_pkg::ADDR_START: reg_rdata <= {convert_flag_reg, 7'h00} |
          adcc_pkg::START_FIXED_ONES; // RULE_10 RULE_14
        adcc_pkg::ADDR_IRQ: reg_rdata <= {6'h00, conversion_done_irq_enable_reg,
          conversion_done_request_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // adcc_core

`default_nettype wire

// [adcc_core_properties.sv]
// Concurrent checks on the ports of the conversion control block
`timescale 1ns/1ns
`default_nettype none
module adcc_core_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Converter side
  input wire logic input_active,
  input wire logic sample_hold,
  input wire logic conversion_done_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Register port
  a_read_slot_only: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_mode_fixed_ones: assert property (reg_rd && reg_addr == adcc_pkg::ADDR_MODE |=>
    reg_rdata[5:4] == 2'h3) else $error("mode bits 5 and 4 not one");
  a_start_fixed_ones: assert property (reg_rd && reg_addr == adcc_pkg::ADDR_START |=>
    reg_rdata[6:0] == 7'h7F) else $error("start bits 6 to 0 not one");
  a_busy_flag_set: assert property (reg_rd && reg_addr == adcc_pkg::ADDR_START && sample_hold
    && $past(sample_hold) && !$past(reg_wr && reg_addr == adcc_pkg::ADDR_START)
    |=> reg_rdata[7]) else $error("flag low while sampling");
  // ==========================================================================
  // Conversion control
  a_start_samples: assert property (reg_wr && reg_addr == adcc_pkg::ADDR_START && reg_wdata[7]
    |-> ##2 sample_hold) else $error("start did not sample");
  a_stop_halts_now: assert property (reg_wr && reg_addr == adcc_pkg::ADDR_START && !reg_wdata[7]
    |-> ##2 !sample_hold [*8]) else $error("stop did not halt");
  a_chan_decode_ok: assert property (reg_wr && reg_addr == adcc_pkg::ADDR_MODE |-> ##2
    input_active == ($past(reg_wdata[3], 2) ^ $past(reg_wdata[2], 2))) else $error("decode");
  a_irq_clear_drop: assert property (reg_wr && reg_addr == adcc_pkg::ADDR_IRQ && !reg_wdata[0]
    |-> ##2 !conversion_done_irq) else $error("irq not cleared");
  c_start: cover property (reg_wr && reg_addr == adcc_pkg::ADDR_START && reg_wdata[7]);
  c_irq: cover property ($rose(conversion_done_irq));
  c_chan: cover property ($rose(input_active));
endmodule // adcc_core_properties
`default_nettype wire

// [adcc_core_tb.sv]
// Self-checking testbench for the conversion control block
`timescale 1ns/1ns
`default_nettype none
module adcc_core_tb;
  localparam logic [1:0] AM = adcc_pkg::ADDR_MODE;
  localparam logic [1:0] AR = adcc_pkg::ADDR_RESULT;
  localparam logic [1:0] AS = adcc_pkg::ADDR_START;
  localparam logic [1:0] AQ = adcc_pkg::ADDR_IRQ;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_trigger_pin = 1'b0;
  logic trigger_edge_select = 1'b1;
  logic [7:0] level = 8'h00;
  logic [7:0] reg_rdata, dac_code;
  logic [2:0] input_select;
  logic input_active, sample_hold, conversion_done_irq, compare_above;
  int bad_count = 0;
  int total_checks = 0;
  // Ideal comparator in place of the analog ladder
  assign compare_above = (level >= dac_code);
  always #5 ref_clk = ~ref_clk;
  adcc_core adcc_core_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trigger_pin(ext_trigger_pin), .trigger_edge_select(trigger_edge_select),
    .compare_above(compare_above), .dac_code(dac_code), .input_select(input_select),
    .input_active(input_active), .sample_hold(sample_hold),
    .conversion_done_irq(conversion_done_irq));
  // ==========================================================================
  // Bus and compare tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    rd(AM, 8'h30, "mode");
    rd(AS, 8'h7F, "start");
    rd(AQ, 8'h00, "irq");
  endtask
  task automatic t_fixed_bits();
    wr(AM, 8'h0F);
    rd(AM, 8'h3F, "mode");
    wr(AS, 8'h00);
    rd(AS, 8'h7F, "start");
  endtask
  task automatic t_channels();
    for (int c = 0; c < 16; c++) begin
      wr(AM, 8'(c));
      @(posedge ref_clk);
      #1 check({7'h0, input_active}, {7'h0, c[3] ^ c[2]}, "active");
      if (c[3] ^ c[2]) check({5'h0, input_select}, {5'h0, c[3], c[1:0]}, "sel");
    end
  endtask
  task automatic t_convert(input logic fast, input logic en, input logic [7:0] lvl);
    level <= lvl;
    wr(AQ, {6'h0, en, 1'b0});
    wr(AM, {fast, 3'h3, 4'h5});
    wr(AS, 8'h80);
    repeat (fast ? 31 : 62) @(posedge ref_clk);
    #1 check({7'h0, conversion_done_irq}, 8'h00, "early");
    @(posedge ref_clk);
    #1 check({7'h0, conversion_done_irq}, {7'h0, en}, "irq");
    rd(AR, lvl, "result");
    rd(AS, 8'h7F, "flag");
    rd(AQ, {6'h0, en, 1'b1}, "request");
    repeat (70) @(posedge ref_clk);
    rd(AS, 8'h7F, "idle");
    rd(AR, lvl, "held");
    wr(AQ, 8'h00);
  endtask
  task automatic t_stop();
    level <= 8'h5A;
    wr(AS, 8'h80);
    rd(AS, 8'hFF, "busy");
    wr(AS, 8'h00);
    repeat (70) @(posedge ref_clk);
    rd(AS, 8'h7F, "stopped");
    rd(AR, 8'hC3, "kept");
    rd(AQ, 8'h00, "no request");
  endtask
  task automatic t_trigger();
    level <= 8'h81;
    wr(AM, 8'h35);
    ext_trigger_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(AS, 8'h7F, "gated");
    ext_trigger_pin <= 1'b0;
    wr(AM, 8'hF5);
    rd(AM, 8'hF5, "mode");
    for (int p = 1; p >= 0; p--) begin
      trigger_edge_select <= p[0];
      ext_trigger_pin <= p[0];
      repeat (5) @(posedge ref_clk);
      rd(AS, 8'hFF, "trig");
      repeat (40) @(posedge ref_clk);
      rd(AR, 8'h81, "trig result");
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run is about 550 cycles; the limit leaves ample margin
  initial begin
    repeat (6000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end
  initial begin
    do_reset();
    t_reset_values();
    t_fixed_bits();
    t_channels();
    t_convert(1'b1, 1'b0, 8'h3C);
    t_convert(1'b0, 1'b1, 8'hC3);
    t_stop();
    t_trigger();
    do_reset();
    rd(AR, 8'h81, "after reset");
    t_reset_values();
    close_out();
  end
endmodule // adcc_core_tb
bind adcc_core adcc_core_properties adcc_core_properties_inst (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .input_active(input_active), .sample_hold(sample_hold),
  .conversion_done_irq(conversion_done_irq));
`default_nettype wire
